// [verilog/intc_pkg.sv]
`default_nettype none
package intc_pkg;
    // Instruction timing in core clocks.
    localparam int unsigned INSTR_CLKS   = 4;
    localparam int unsigned DETECT_INSTR = 1;
    localparam int unsigned CALL_INSTR   = 4;
    localparam int unsigned DETECT_CLKS  = INSTR_CLKS * DETECT_INSTR;
    localparam int unsigned CALL_CLKS    = INSTR_CLKS * CALL_INSTR;

    // Register indices; the byte address is four times the index.
    localparam logic [15:0] IDX_FLAGS    = 16'h2840;
    localparam logic [15:0] IDX_INTYPE   = 16'h2841;
    localparam logic [15:0] IDX_OUTTYPE  = 16'h2842;
    localparam logic [15:0] IDX_ENABLES  = 16'h2843;
    localparam logic [15:0] IDX_PENDING  = 16'h2844;
    localparam logic [15:0] IDX_CTRL     = 16'h2850;
    localparam logic [15:0] IDX_STATUS   = 16'h2851;
    localparam logic [15:0] IDX_PWR_CTRL = 16'h2d01;

    // Field positions.
    localparam int unsigned PWR_GATE_BIT  = 0;
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_RANK_BIT = 1;
    localparam int unsigned CTRL_FLAG_BIT = 4;

    // Reset values and implemented bits.
    localparam logic [7:0] IMPL_MASK    = 8'hbf;
    localparam logic [7:0] RST_INTYPE   = 8'hbf;
    localparam logic [7:0] RST_OUTTYPE  = 8'h01;
    localparam logic [7:0] RST_ZERO     = 8'h00;

    // Vectors.
    localparam int unsigned NUM_SRC  = 9;
    localparam int unsigned EXT8_IDX = 8;
    localparam logic [7:0]  VEC_BASE = 8'h03;
    localparam logic [7:0]  VEC_STEP = 8'h08;
    localparam logic [7:0]  EXT8_VEC = 8'h43;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_DETECT = 2'b01,
        ST_CALL   = 2'b11
    } call_state_t;

    typedef struct packed {
        logic instr_end;
        logic is_return_from_handler_opcode;
        logic is_guard;
    } core_step_t;

    typedef struct packed {
        logic flags;
        logic intype;
        logic outtype;
        logic enables;
        logic pending;
    } ext8_wr_t;
endpackage
`default_nettype wire

// [verilog/ext8_aggregator.sv]
`timescale 1ns/1ps
`default_nettype none
module ext8_aggregator (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    input  wire logic                 ce,
    // Peripheral events
    input  wire logic [7:0]           ev_in,
    // Register writes
    input  wire intc_pkg::ext8_wr_t   wr,
    input  wire logic [7:0]           wdata,
    // Register contents
    output logic      [7:0]           flags_r,
    output logic      [7:0]           intype_r,
    output logic      [7:0]           outtype_r,
    output logic      [7:0]           enables_r,
    output logic      [7:0]           pending_r
);
    logic [7:0] ev_prev_r;
    logic [7:0] ev_hit;

    // ==========================================================
    // Event detection
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            ev_prev_r <= intc_pkg::RST_ZERO;
        else if (ce)
            ev_prev_r <= ev_in;
    end

    // Edge type detects a rising event, level type follows the input.
    assign ev_hit = ((intype_r & ev_in & ~ev_prev_r) | (~intype_r & ev_in))
                    & intc_pkg::IMPL_MASK;

    // ==========================================================
    // Configuration registers
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            intype_r  <= intc_pkg::RST_INTYPE;
            outtype_r <= intc_pkg::RST_OUTTYPE;
            enables_r <= intc_pkg::RST_ZERO;
        end
        else if (ce)
        begin
            if (wr.intype)
                intype_r <= wdata & intc_pkg::IMPL_MASK;
            if (wr.outtype)
                outtype_r <= wdata & intc_pkg::IMPL_MASK;
            if (wr.enables)
                enables_r <= wdata & intc_pkg::IMPL_MASK;
        end
    end

    // ==========================================================
    // Per-source flag and overrun bits
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_src
            if (intc_pkg::IMPL_MASK[i])
            begin : g_impl
                always_ff @(posedge clk_sys)
                begin
                    if (!nrst)
                        flags_r[i] <= 1'b0;
                    else if (ce)
                    begin
                        if (ev_hit[i] && enables_r[i])
                            flags_r[i] <= 1'b1;
                        else if (wr.flags)
                            flags_r[i] <= wdata[i] & (flags_r[i] | enables_r[i]);
                    end
                end
                always_ff @(posedge clk_sys)
                begin
                    if (!nrst)
                        pending_r[i] <= 1'b0;
                    else if (ce)
                    begin
                        if (ev_hit[i] && flags_r[i])
                            pending_r[i] <= 1'b1;
                        else if (wr.pending)
                            pending_r[i] <= wdata[i];
                    end
                end
            end
            else
            begin : g_unused
                assign flags_r[i]   = 1'b0;
                assign pending_r[i] = 1'b0;
            end
        end
    endgenerate

    // ==========================================================
    // Assertions
    a_flag_needs_enable: assert property (@(posedge clk_sys) disable iff (!nrst)
        (flags_r & ~$past(flags_r) & ~$past(enables_r)) == 8'h00)
        else $error("flag rose while its enable was clear");
    a_flag_write_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && wr.flags && wdata == 8'h00 && ev_hit == 8'h00 |=> flags_r == 8'h00)
        else $error("writing zero did not clear the flags");
    a_overrun_mark: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && (ev_hit & flags_r) != 8'h00 |=> (pending_r & $past(ev_hit & flags_r))
        == $past(ev_hit & flags_r))
        else $error("overrun not recorded");
    a_bit6_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
        !flags_r[6] && !pending_r[6] && !enables_r[6] && !intype_r[6])
        else $error("unused bit six is not zero");
endmodule // ext8_aggregator
`default_nettype wire

// [verilog/intc_top.sv]
// Contract
// - Accepted interrupt vectors core; only higher preempts
// - Return resumes interrupted code or handler
// - Finish instruction; one more after guards
// - Tier one beats tier zero, never reverse
// - Same tier: fixed polling order decides
// - Least latency five instruction cycles
// - Worst latency thirteen cycles, fifty-two clocks
// - Unserved level request stays asserted
// - Interrupt 8 merges seven, gated power bit0
// - Interrupt 8 vectors 43h, fixed bit map
// - Flag sets only while enabled
// - Software one sets only when enabled
// - Software zero clears flag
// - Recurring event sets overrun bit
// - Enable bits, reset to zero
// - Top flag software cleared, software settable
// - Priority bit picks tier for interrupt 8
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
module intc_top #(
    parameter int unsigned ADDR_W = 16
) (
    // Clock, reset, enable
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire logic                  ce,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]     awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic      [1:0]            bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [ADDR_W-1:0]     araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic      [31:0]           rdata,
    output logic      [1:0]            rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // Core side
    input  wire intc_pkg::core_step_t  step,
    input  wire logic [7:0]            src_req,
    input  wire logic [7:0]            src_rank,
    output logic                       handler_entry,
    output logic      [7:0]            handler_vector,
    output logic                       call_busy,
    output logic      [1:0]            in_service,
    // Interrupt 8 peripheral events
    input  wire logic [7:0]            ext8_events
);
    logic [7:0]               flags_r;
    logic [7:0]               intype_r;
    logic [7:0]               outtype_r;
    logic [7:0]               enables_r;
    logic [7:0]               pending_r;
    logic [7:0]               pwr_ctrl_r;
    logic                     ext8_en_r;
    logic                     ext8_rank_r;
    logic                     top_flag_r;
    logic                     aw_got_r;
    logic                     w_got_r;
    logic [ADDR_W-1:0]        aw_addr_r;
    logic [7:0]               w_byte_r;
    logic                     w_lane_r;
    logic                     wr_fire;
    logic [15:0]              wr_idx;
    logic [15:0]              rd_idx;
    logic                     rd_hit;
    logic [7:0]               rd_byte;
    intc_pkg::ext8_wr_t       ext_wr;
    intc_pkg::call_state_t    state_r;
    logic [4:0]               cnt_r;
    logic [3:0]               win_r;
    logic [intc_pkg::NUM_SRC-1:0] req_all;
    logic [intc_pkg::NUM_SRC-1:0] rank_all;
    logic                     have_win;
    logic                     win_tier;
    logic [3:0]               win_idx;
    logic                     accept;

    // ==========================================================
    // AXI4-Lite write path
    assign wr_idx  = 16'(aw_addr_r >> 2);
    assign wr_fire = aw_got_r && w_got_r && !bvalid;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            aw_addr_r <= '0;
            w_byte_r  <= intc_pkg::RST_ZERO;
            w_lane_r  <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= intc_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (awvalid && awready)
            begin
                aw_addr_r <= awaddr;
                aw_got_r  <= 1'b1;
                awready   <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_byte_r <= wdata[7:0];
                w_lane_r <= wstrb[0];
                w_got_r  <= 1'b1;
                wready   <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid   <= 1'b1;
                bresp    <= addr_ok(wr_idx, aw_addr_r[1:0]) ? intc_pkg::RESP_OKAY
                                                           : intc_pkg::RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    function automatic logic addr_ok(input logic [15:0] idx, input logic [1:0] lo);
        addr_ok = (lo == 2'b00) && (idx == intc_pkg::IDX_FLAGS || idx == intc_pkg::IDX_INTYPE
                  || idx == intc_pkg::IDX_OUTTYPE || idx == intc_pkg::IDX_ENABLES
                  || idx == intc_pkg::IDX_PENDING || idx == intc_pkg::IDX_CTRL
                  || idx == intc_pkg::IDX_STATUS || idx == intc_pkg::IDX_PWR_CTRL);
    endfunction

    always_comb
    begin
        ext_wr         = '0;
        ext_wr.flags   = wr_fire && w_lane_r && wr_idx == intc_pkg::IDX_FLAGS;
        ext_wr.intype  = wr_fire && w_lane_r && wr_idx == intc_pkg::IDX_INTYPE;
        ext_wr.outtype = wr_fire && w_lane_r && wr_idx == intc_pkg::IDX_OUTTYPE;
        ext_wr.enables = wr_fire && w_lane_r && wr_idx == intc_pkg::IDX_ENABLES;
        ext_wr.pending = wr_fire && w_lane_r && wr_idx == intc_pkg::IDX_PENDING;
    end

    // ==========================================================
    // Interrupt 8 gate, control and top flag
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            pwr_ctrl_r  <= intc_pkg::RST_ZERO;
            ext8_en_r   <= 1'b0;
            ext8_rank_r <= 1'b0;
        end
        else if (ce && wr_fire && w_lane_r)
        begin
            if (wr_idx == intc_pkg::IDX_PWR_CTRL)
                pwr_ctrl_r <= w_byte_r;
            if (wr_idx == intc_pkg::IDX_CTRL)
            begin
                ext8_en_r   <= w_byte_r[intc_pkg::CTRL_EN_BIT];
                ext8_rank_r <= w_byte_r[intc_pkg::CTRL_RANK_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            top_flag_r <= 1'b0;
        else if (ce)
        begin
            if (pwr_ctrl_r[intc_pkg::PWR_GATE_BIT] && |(flags_r & enables_r))
                top_flag_r <= 1'b1;
            else if (wr_fire && w_lane_r && wr_idx == intc_pkg::IDX_CTRL)
                top_flag_r <= w_byte_r[intc_pkg::CTRL_FLAG_BIT];
        end
    end

    ext8_aggregator u_ext8 (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .ce        (ce),
        .ev_in     (ext8_events),
        .wr        (ext_wr),
        .wdata     (w_byte_r),
        .flags_r   (flags_r),
        .intype_r  (intype_r),
        .outtype_r (outtype_r),
        .enables_r (enables_r),
        .pending_r (pending_r)
    );

    // ==========================================================
    // AXI4-Lite read path
    assign rd_idx = 16'(araddr >> 2);
    assign rd_hit = addr_ok(rd_idx, araddr[1:0]);

    always_comb
    begin
        case (rd_idx)
            intc_pkg::IDX_FLAGS:    rd_byte = flags_r;
            intc_pkg::IDX_INTYPE:   rd_byte = intype_r;
            intc_pkg::IDX_OUTTYPE:  rd_byte = outtype_r;
            intc_pkg::IDX_ENABLES:  rd_byte = enables_r;
            intc_pkg::IDX_PENDING:  rd_byte = pending_r;
            intc_pkg::IDX_PWR_CTRL: rd_byte = pwr_ctrl_r;
            intc_pkg::IDX_CTRL:     rd_byte = {3'b000, top_flag_r, 2'b00, ext8_rank_r, ext8_en_r};
            intc_pkg::IDX_STATUS:   rd_byte = {state_r, 2'b00, win_r};
            default:                rd_byte = intc_pkg::RST_ZERO;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= intc_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (arvalid && arready)
            begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
                rresp   <= rd_hit ? intc_pkg::RESP_OKAY : intc_pkg::RESP_SLVERR;
            end
            else if (rvalid && rready)
            begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Arbitration
    // Requests are levels sampled at each boundary, so an unserved one waits.
    assign req_all  = {top_flag_r && ext8_en_r, src_req};
    assign rank_all = {ext8_rank_r, src_rank};

    always_comb
    begin
        have_win = 1'b0;
        win_tier = 1'b0;
        win_idx  = 4'h0;
        for (int t = 1; t >= 0; t--)
        begin
            for (int k = intc_pkg::NUM_SRC - 1; k >= 0; k--)
            begin
                if (!have_win && req_all[k] && rank_all[k] == t[0])
                begin
                    win_idx  = 4'(k);
                end
            end
            if (!have_win && |(req_all & (t[0] ? rank_all : ~rank_all)))
            begin
                have_win = 1'b1;
                win_tier = t[0];
            end
        end
    end

    // Only a strictly higher tier than every handler in service may enter.
    assign accept = step.instr_end && !step.is_return_from_handler_opcode && !step.is_guard
                    && have_win && !in_service[1] && (win_tier || !in_service[0]);

    // ==========================================================
    // Call sequencing: detect, then the long call, then entry
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            state_r        <= intc_pkg::ST_IDLE;
            cnt_r          <= 5'h00;
            win_r          <= 4'h0;
            handler_entry  <= 1'b0;
            handler_vector <= 8'h00;
            call_busy      <= 1'b0;
        end
        else if (ce)
        begin
            handler_entry <= 1'b0;
            case (state_r)
                intc_pkg::ST_IDLE:
                begin
                    if (accept)
                    begin
                        state_r   <= intc_pkg::ST_DETECT;
                        cnt_r     <= 5'(intc_pkg::DETECT_CLKS - 1);
                        win_r     <= win_idx;
                        call_busy <= 1'b1;
                    end
                end
                intc_pkg::ST_DETECT:
                begin
                    if (cnt_r == 5'h00)
                    begin
                        state_r <= intc_pkg::ST_CALL;
                        cnt_r   <= 5'(intc_pkg::CALL_CLKS - 1);
                    end
                    else
                        cnt_r <= cnt_r - 5'h01;
                end
                intc_pkg::ST_CALL:
                begin
                    if (cnt_r == 5'h00)
                    begin
                        state_r        <= intc_pkg::ST_IDLE;
                        call_busy      <= 1'b0;
                        handler_entry  <= 1'b1;
                        handler_vector <= 8'(intc_pkg::VEC_BASE
                                          + intc_pkg::VEC_STEP * win_r);
                    end
                    else
                        cnt_r <= cnt_r - 5'h01;
                end
                default:
                    state_r <= intc_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Handler nesting: push on entry, pop on return
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            in_service <= 2'b00;
        else if (ce)
        begin
            if (state_r == intc_pkg::ST_CALL && cnt_r == 5'h00)
                in_service[rank_all[win_r]] <= 1'b1;
            else if (step.instr_end && step.is_return_from_handler_opcode)
            begin
                if (in_service[1])
                    in_service[1] <= 1'b0;
                else
                    in_service[0] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Assertions
    a_ext8_vector: assert property (@(posedge clk_sys) disable iff (!nrst)
        handler_entry && $past(win_r) == 4'(intc_pkg::EXT8_IDX)
        |-> handler_vector == intc_pkg::EXT8_VEC)
        else $error("interrupt 8 did not vector to 43h");
    a_call_latency: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        state_r == intc_pkg::ST_IDLE && accept |=> ##20 handler_entry)
        else $error("handler entry not twenty clocks after acceptance");
    a_guard_delay: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        state_r == intc_pkg::ST_IDLE && step.instr_end && (step.is_return_from_handler_opcode || step.is_guard)
        |=> state_r == intc_pkg::ST_IDLE)
        else $error("interrupt taken right after a guarded instruction");
    a_tier_hold: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        state_r == intc_pkg::ST_IDLE && in_service[1] |=> state_r == intc_pkg::ST_IDLE)
        else $error("tier one handler was preempted");
    a_return_from_handler_opcode_pop: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        in_service == 2'b11 && step.instr_end && step.is_return_from_handler_opcode
        && !(state_r == intc_pkg::ST_CALL && cnt_r == 5'h00) |=> in_service == 2'b01)
        else $error("return did not resume the preempted handler");
    a_poll_first: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        accept && req_all[0] && rank_all[0] == win_tier |=> win_r == 4'h0)
        else $error("polling order not kept");
    a_top_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        pwr_ctrl_r[intc_pkg::PWR_GATE_BIT] && |(flags_r & enables_r) |=> top_flag_r)
        else $error("top flag not raised by an enabled sub-flag");
    a_gate_block: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(top_flag_r) && !$past(pwr_ctrl_r[intc_pkg::PWR_GATE_BIT]) |->
        $past(wr_fire && wr_idx == intc_pkg::IDX_CTRL))
        else $error("top flag raised with the power gate clear");

    c_entry:   cover property (@(posedge clk_sys) disable iff (!nrst) handler_entry);
    c_nested:  cover property (@(posedge clk_sys) disable iff (!nrst) in_service == 2'b11);
    c_ext8:    cover property (@(posedge clk_sys) disable iff (!nrst)
        handler_entry && handler_vector == intc_pkg::EXT8_VEC);
endmodule // intc_top
`default_nettype wire

// [sim/core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                nrst,
    // Boundary qualifiers
    input  wire logic                return_from_handler_opcode,
    input  wire logic                guard,
    // Core step
    output var intc_pkg::core_step_t step
);
    logic [1:0] cnt_r;
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            cnt_r <= 2'h0;
        else
            cnt_r <= cnt_r + 2'h1;
    end
    // An instruction cycle is four clocks; qualifiers only count at its boundary.
    always_comb
    begin
        step.instr_end = (cnt_r == 2'h3);
        step.is_return_from_handler_opcode   = step.instr_end & return_from_handler_opcode;
        step.is_guard  = step.instr_end & guard;
    end
endmodule // core_model
`default_nettype wire

// [sim/intc_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module intc_top_tb;
    logic        clk_sys, nrst, awvalid, wvalid, bready, arvalid, rready, return_from_handler_opcode, guard;
    logic        awready, wready, bvalid, arready, rvalid, handler_entry, call_busy;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata, lfsr;
    logic [1:0]  bresp, rresp, in_service;
    logic [7:0]  src_req, src_rank, ev, vec, e, v, f;
    intc_pkg::core_step_t step;
    int          failures, checks, i;
    localparam logic [7:0] RST_V [5] = '{8'h00, 8'hbf, 8'h01, 8'h00, 8'h00};
    core_model u_core (.clk_sys(clk_sys), .nrst(nrst), .return_from_handler_opcode(return_from_handler_opcode), .guard(guard), .step(step));
    intc_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .step(step), .src_req(src_req), .src_rank(src_rank), .handler_entry(handler_entry),
        .handler_vector(vec), .call_busy(call_busy), .in_service(in_service), .ext8_events(ev));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        @(posedge clk_sys);
        awaddr <= {idx[13:0], 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(bresp, intc_pkg::RESP_OKAY);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] x, input logic [1:0] r);
        @(posedge clk_sys);
        araddr <= {idx[13:0], 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, {24'h0, x});
        chk(rresp, r);
    endtask
    task automatic pulse(input logic [7:0] p);
        ev <= p;
        repeat (4) @(posedge clk_sys);
        ev <= 8'h00;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic wait_entry(input logic [7:0] x);
        int n;
        n = 0;
        while (!call_busy) @(posedge clk_sys);
        while (!handler_entry && n < 99)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk(n, intc_pkg::DETECT_CLKS + intc_pkg::CALL_CLKS);
        chk(vec, x);
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial
    begin
        #60000;
        failures++;
        end_sim();
    end
    initial
    begin
        {nrst, awvalid, wvalid, bready, arvalid, rready, return_from_handler_opcode, guard} = '0;
        {awaddr, araddr, wdata, src_req, src_rank, ev} = '0;
        lfsr = 32'h5f95;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        for (i = 0; i < 5; i++)
            rd(intc_pkg::IDX_FLAGS + 16'(i), RST_V[i], intc_pkg::RESP_OKAY);
        rd(16'h0100, 8'h00, intc_pkg::RESP_SLVERR);
        wr(intc_pkg::IDX_ENABLES, 8'hff);
        rd(intc_pkg::IDX_ENABLES, 8'hbf, intc_pkg::RESP_OKAY);
        $display("reset and map test done");
        lfsr = nxt(lfsr);
        e = lfsr[7:0] | 8'h01;
        lfsr = nxt(lfsr);
        v = lfsr[7:0] | 8'h01;
        wr(intc_pkg::IDX_ENABLES, e);
        pulse(v);
        f = v & e & 8'hbf;
        rd(intc_pkg::IDX_FLAGS, f, intc_pkg::RESP_OKAY);
        lfsr = nxt(lfsr);
        pulse(lfsr[7:0]);
        rd(intc_pkg::IDX_PENDING, lfsr[7:0] & f, intc_pkg::RESP_OKAY);
        wr(intc_pkg::IDX_PWR_CTRL, 8'h01);
        wr(intc_pkg::IDX_CTRL, 8'h01);
        wait_entry(intc_pkg::EXT8_VEC);
        wr(intc_pkg::IDX_FLAGS, 8'h00);
        rd(intc_pkg::IDX_FLAGS, 8'h00, intc_pkg::RESP_OKAY);
        wr(intc_pkg::IDX_ENABLES, 8'h02);
        wr(intc_pkg::IDX_FLAGS, 8'hff);
        rd(intc_pkg::IDX_FLAGS, 8'h02, intc_pkg::RESP_OKAY);
        $display("aggregator test done");
        src_rank <= 8'h0d;
        src_req <= 8'h0d;
        guard <= 1'b1;
        while (!step.is_guard) @(posedge clk_sys);
        guard <= 1'b0;
        @(posedge clk_sys);
        chk(call_busy, 1'b0);
        wait_entry(8'h03);
        src_req <= 8'h00;
        @(posedge clk_sys);
        chk(in_service, 2'b11);
        return_from_handler_opcode <= 1'b1;
        while (!step.is_return_from_handler_opcode) @(posedge clk_sys);
        return_from_handler_opcode <= 1'b0;
        @(posedge clk_sys);
        chk(in_service, 2'b01);
        rd(intc_pkg::IDX_CTRL, 8'h11, intc_pkg::RESP_OKAY);
        $display("core test done");
        end_sim();
    end
endmodule // intc_top_tb
`default_nettype wire
